//--- hdl/hcm_top.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Per-channel mode: 0 burnout, 1 measurement
// - Measurement mode: continuous on-current, off zero
// - Selector picks watched control or event output
// - Wait 30 to 300 ms, default 30
// - Burnout sample starts after wait, measurement sample at once; lasts 100 ms
// - Turns 1-40 times hundred; 0 means 800
// - Loops 1-6 passes; 0 means one
// - Ranges derived from turns divided by loops
// - Over display range, unless saturated, raises input failure alarm
// - Range arithmetic error below a tenth ampere
// - Second channel settings exist only when dual
// - Burnout: on-current when on, off-current off
// - Small current changes smoothed by filter
module hcm_top
    import hcm_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ctl_out,
    input wire logic [2:0] evt_out,
    input wire hcm_cur_t ct_sample_1,
    input wire hcm_cur_t ct_sample_2,
    input wire logic dual_ct_strap,
    output logic [1:0] ct_input_failure_alarm,
    output logic hcm_irq
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic pick_out(input logic [2:0] sel, input logic [1:0] ctl,
                                      input logic [2:0] evt);
        case (sel)
            3'h1: pick_out = ctl[1];
            3'h2: pick_out = evt[0];
            3'h3: pick_out = evt[1];
            3'h4: pick_out = evt[2];
            default: pick_out = ctl[0];
        endcase
    endfunction : pick_out

    function automatic logic [8:0] clamp_wait(input logic [8:0] v);
        if (v < WAIT_MIN_MS) begin
            clamp_wait = WAIT_MIN_MS;
        end else if (v > WAIT_MAX_MS) begin
            clamp_wait = WAIT_MAX_MS;
        end else begin
            clamp_wait = v;
        end
    endfunction : clamp_wait

    function automatic logic [5:0] eff_turns(input logic [5:0] v);
        eff_turns = (v == 6'h00) ? TURNS_DEF : v;
    endfunction : eff_turns

    function automatic logic [2:0] eff_loops(input logic [2:0] v);
        eff_loops = (v == 3'h0) ? LOOPS_DEF : v;
    endfunction : eff_loops

    // ****************************************
    // Strap capture
    // ****************************************
    logic strap_s1_r;
    logic strap_s2_r;
    logic [1:0] settle_r;
    logic dual_r;

    // Strap is caught once after reset; later pin changes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
            settle_r <= 2'h0;
            dual_r <= 1'b0;
        end else begin
            strap_s1_r <= dual_ct_strap;
            strap_s2_r <= strap_s1_r;
            // Second stage shows the pin only from the second edge on
            if (settle_r != STRAP_SETTLE + 2'h1) begin
                settle_r <= settle_r + 2'h1;
            end
            if (settle_r == STRAP_SETTLE) begin
                dual_r <= strap_s2_r;
            end
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    wire logic acc_start = psel & penable & ~pready_r;
    wire logic acc_done = psel & penable & pready_r;
    wire logic wr_en = acc_done & pwrite;
    wire logic hit_ctrl = (paddr == OFS_CTRL);
    wire logic hit_wait = (paddr == OFS_WAIT);
    wire logic hit_tl = (paddr == OFS_TURNLOOP);
    wire logic hit_meas1 = (paddr == OFS_MEAS1);
    wire logic hit_meas2 = (paddr == OFS_MEAS2);
    wire logic hit_rng1 = (paddr == OFS_RANGE1);
    wire logic hit_rng2 = (paddr == OFS_RANGE2);
    wire logic hit_rlo = (paddr == OFS_RANGE_LO);
    wire logic hit_ists = (paddr == OFS_INT_STS);
    wire logic hit_imask = (paddr == OFS_INT_MASK);
    wire logic hit_stat = (paddr == OFS_STATUS);
    wire logic hit_any = hit_ctrl | hit_wait | hit_tl | hit_meas1 | hit_meas2 | hit_rng1
                       | hit_rng2 | hit_rlo | hit_ists | hit_imask | hit_stat;

    // ****************************************
    // Channels
    // ****************************************
    hcm_cfg_s cfg_r [2];
    hcm_range_s rng_r [2];
    hcm_meas_s meas [2];
    hcm_cur_t samp [2];
    logic [1:0] done;
    logic [1:0] busy;
    logic [1:0] alarm_r;
    logic [1:0] alarm_ev;

    assign samp[0] = ct_sample_1;
    assign samp[1] = ct_sample_2;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            // Channel 2 takes settings only when the strap reads dual; channel 1 always does
            wire logic ch_ok = (i == 0) | dual_r;
            wire logic wr_cfg = wr_en & ch_ok;
            wire logic [5:0] wt = pwdata[CH_STEP * i + TL_TURNS_LSB +: 6];
            wire logic [2:0] wl = pwdata[CH_STEP * i + TL_LOOPS_LSB +: 3];
            wire logic [5:0] t_eff = eff_turns(cfg_r[i].turns);
            wire logic [15:0] l_eff = {13'h0000, eff_loops(cfg_r[i].loops)};
            wire logic [15:0] t_w = {10'h000, t_eff};
            wire logic mon = pick_out(cfg_r[i].sel, ctl_out, evt_out);
            // Values in 0.01 A so truncation stays far below 0.1 A
            wire logic [15:0] r_meas_hi = 16'((t_w * MEAS_HI_K) / l_eff);
            wire logic [15:0] r_disp_hi = 16'((t_w * DISP_HI_K) / l_eff);
            wire logic [15:0] r_meas_lo = 16'((t_w * MEAS_LO_K) / l_eff);
            // Saturated converter code is not trusted, so no alarm then
            wire logic over = (meas[i].last_cur > rng_r[i].disp_hi)
                            && (meas[i].last_cur != SAT_CODE);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r[i] <= '{OP_DEF, SEL_DEF, WAIT_DEF_MS, TURNS_DEF, LOOPS_DEF};
                end else begin
                    if (wr_cfg && hit_ctrl) begin
                        cfg_r[i].op_type <= pwdata[CTRL_OP_LSB + CTRL_OP_STEP * i];
                        cfg_r[i].sel <= pwdata[CTRL_SEL_LSB + CTRL_SEL_STEP * i +: 3];
                    end
                    if (wr_cfg && hit_wait) begin
                        cfg_r[i].wait_ms <= clamp_wait(pwdata[CH_STEP * i + WAIT_LSB +: 9]);
                    end
                    if (wr_cfg && hit_tl) begin
                        cfg_r[i].turns <= (wt > TURNS_MAX) ? TURNS_MAX : wt;
                        cfg_r[i].loops <= (wl > LOOPS_MAX) ? LOOPS_MAX : wl;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rng_r[i] <= '0;
                    alarm_r[i] <= 1'b0;
                end else begin
                    rng_r[i] <= '{r_meas_hi, r_disp_hi, r_meas_lo};
                    if (done[i]) begin
                        alarm_r[i] <= over;
                    end
                end
            end

            assign alarm_ev[i] = done[i] & over;

            hcm_chan #(
                .CYC_MS(CYC_MS)
            ) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .op_type(cfg_r[i].op_type),
                .mon_level(mon),
                .wait_ms(cfg_r[i].wait_ms),
                .sample(samp[i]),
                .meas(meas[i]),
                .done(done[i]),
                .busy(busy[i])
            );
        end
    endgenerate

    // ****************************************
    // Interrupts
    // ****************************************
    logic [3:0] ists_r;
    logic [3:0] imask_r;
    logic irq_r;

    wire logic [3:0] ev = {alarm_ev, done};
    wire logic [3:0] w1c = (wr_en && hit_ists) ? pwdata[3:0] : 4'h0;
    // New events win over a clear in the same cycle
    wire logic [3:0] ists_nxt = (ists_r & ~w1c) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= 4'h0;
            imask_r <= 4'h0;
            irq_r <= 1'b0;
        end else begin
            ists_r <= ists_nxt;
            if (wr_en && hit_imask) begin
                imask_r <= pwdata[3:0];
            end
            irq_r <= |(ists_nxt & imask_r);
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    wire logic [31:0] v_ctrl = {21'h000000, cfg_r[1].sel & {3{dual_r}}, 1'b0,
                                cfg_r[0].sel, 2'h0, cfg_r[1].op_type & dual_r,
                                cfg_r[0].op_type};
    wire logic [31:0] v_wait = {7'h00, cfg_r[1].wait_ms & {9{dual_r}}, 7'h00, cfg_r[0].wait_ms};
    wire logic [31:0] v_tl = {5'h00, cfg_r[1].loops & {3{dual_r}}, 2'h0,
                              cfg_r[1].turns & {6{dual_r}}, 5'h00, cfg_r[0].loops, 2'h0,
                              cfg_r[0].turns};
    wire logic [31:0] v_m1 = {meas[0].off_cur, meas[0].on_cur};
    wire logic [31:0] v_m2 = {meas[1].off_cur, meas[1].on_cur} & {32{dual_r}};
    wire logic [31:0] v_r1 = {rng_r[0].meas_hi, rng_r[0].disp_hi};
    wire logic [31:0] v_r2 = {rng_r[1].meas_hi, rng_r[1].disp_hi} & {32{dual_r}};
    wire logic [31:0] v_rl = {rng_r[1].meas_lo & {16{dual_r}}, rng_r[0].meas_lo};
    wire logic [31:0] v_st = {27'h0000000, alarm_r, busy, dual_r};
    wire logic [31:0] rd_word = ({32{hit_ctrl}} & v_ctrl)
                              | ({32{hit_wait}} & v_wait)
                              | ({32{hit_tl}} & v_tl)
                              | ({32{hit_meas1}} & v_m1)
                              | ({32{hit_meas2}} & v_m2)
                              | ({32{hit_rng1}} & v_r1)
                              | ({32{hit_rng2}} & v_r2)
                              | ({32{hit_rlo}} & v_rl)
                              | ({32{hit_ists}} & {28'h0000000, ists_r})
                              | ({32{hit_imask}} & {28'h0000000, imask_r})
                              | ({32{hit_stat}} & v_st);

    // One wait state: answer is registered from the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= acc_start;
            pslverr_r <= acc_start & ~hit_any;
            if (acc_start && !pwrite) begin
                prdata_r <= rd_word;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign ct_input_failure_alarm = alarm_r;
    assign hcm_irq = irq_r;

endmodule : hcm_top

//--- hdl/hcm_pkg.sv
package hcm_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned MS_PS = 1000000000;
    localparam int unsigned CYC_PER_MS = MS_PS / CLK_PERIOD_PS;
    localparam logic [8:0] WAIT_MIN_MS = 9'h01e;
    localparam logic [8:0] WAIT_MAX_MS = 9'h12c;
    localparam logic [8:0] WAIT_DEF_MS = 9'h01e;
    localparam logic [8:0] WINDOW_MS = 9'h064;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // ****************************************
    // Current arithmetic, units of 0.01 A
    // ****************************************
    localparam logic [15:0] FILT_BAND = 16'h00fa;
    localparam logic [15:0] SAT_CODE = 16'hffff;
    localparam logic [15:0] MEAS_HI_K = 16'h0271;
    localparam logic [15:0] DISP_HI_K = 16'h036b;
    localparam logic [15:0] MEAS_LO_K = 16'h0005;
    localparam logic [5:0] TURNS_DEF = 6'h08;
    localparam logic [5:0] TURNS_MAX = 6'h28;
    localparam logic [2:0] LOOPS_DEF = 3'h1;
    localparam logic [2:0] LOOPS_MAX = 3'h6;
    localparam logic [2:0] SEL_DEF = 3'h0;
    localparam logic OP_DEF = 1'b0;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_WAIT = 12'h004;
    localparam logic [11:0] OFS_TURNLOOP = 12'h008;
    localparam logic [11:0] OFS_MEAS1 = 12'h00c;
    localparam logic [11:0] OFS_MEAS2 = 12'h010;
    localparam logic [11:0] OFS_RANGE1 = 12'h014;
    localparam logic [11:0] OFS_RANGE2 = 12'h018;
    localparam logic [11:0] OFS_RANGE_LO = 12'h01c;
    localparam logic [11:0] OFS_INT_STS = 12'h020;
    localparam logic [11:0] OFS_INT_MASK = 12'h024;
    localparam logic [11:0] OFS_STATUS = 12'h028;

    // ****************************************
    // Field positions (channel stride in STEP)
    // ****************************************
    localparam int unsigned CTRL_OP_LSB = 0;
    localparam int unsigned CTRL_OP_STEP = 1;
    localparam int unsigned CTRL_SEL_LSB = 4;
    localparam int unsigned CTRL_SEL_STEP = 4;
    localparam int unsigned WAIT_LSB = 0;
    localparam int unsigned CH_STEP = 16;
    localparam int unsigned TL_TURNS_LSB = 0;
    localparam int unsigned TL_LOOPS_LSB = 8;
    localparam int unsigned INT_DONE_LSB = 0;
    localparam int unsigned INT_ALARM_LSB = 2;
    localparam int unsigned ST_DUAL_BIT = 0;
    localparam int unsigned ST_BUSY_LSB = 1;
    localparam int unsigned ST_ALARM_LSB = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [15:0] hcm_cur_t;

    typedef struct packed {
        logic op_type;
        logic [2:0] sel;
        logic [8:0] wait_ms;
        logic [5:0] turns;
        logic [2:0] loops;
    } hcm_cfg_s;

    typedef struct packed {
        hcm_cur_t off_cur;
        hcm_cur_t on_cur;
        hcm_cur_t last_cur;
    } hcm_meas_s;

    typedef struct packed {
        hcm_cur_t meas_hi;
        hcm_cur_t disp_hi;
        hcm_cur_t meas_lo;
    } hcm_range_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT,
        SEQ_SAMP
    } hcm_seq_e;

endpackage : hcm_pkg

//--- hdl/hcm_chan.sv
`timescale 1ns/1ps
module hcm_chan
    import hcm_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic op_type,
    input wire logic mon_level,
    input wire logic [8:0] wait_ms,
    input wire hcm_cur_t sample,
    output hcm_meas_s meas,
    output logic done,
    output logic busy
);

    // ****************************************
    // Filter: small steps creep, large steps jump
    // ****************************************
    function automatic hcm_cur_t filt(input hcm_cur_t old, input hcm_cur_t nw);
        hcm_cur_t dif;
        hcm_cur_t step;
        dif = (nw >= old) ? nw - old : old - nw;
        step = dif >> 3;
        if (step == 16'h0000 && dif != 16'h0000) begin
            step = 16'h0001;
        end
        if (dif > FILT_BAND) begin
            filt = nw;
        end else if (nw >= old) begin
            filt = old + step;
        end else begin
            filt = old - step;
        end
    endfunction : filt

    // ****************************************
    // Sequencer
    // ****************************************
    localparam logic [17:0] PRE_LAST = 18'(CYC_MS - 1);

    hcm_seq_e state_r, state_nxt;
    logic [17:0] pre_r;
    logic [8:0] ms_r;
    logic mon_d_r;
    logic lvl_r;
    logic done_r;
    hcm_meas_s meas_r;

    wire logic toggle = (mon_level ^ mon_d_r) & ~op_type;
    wire logic tick = (pre_r == PRE_LAST);
    wire logic wait_end = tick && (ms_r == wait_ms - 9'h001);
    wire logic samp_end = tick && (ms_r == WINDOW_MS - 9'h001);
    wire logic fin = (state_r == SEQ_SAMP) && samp_end && !toggle;
    wire logic moved = (state_nxt != state_r) || toggle || fin;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SEQ_IDLE: begin
                if (op_type) begin
                    state_nxt = SEQ_SAMP;
                end else if (toggle) begin
                    state_nxt = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (op_type || (wait_end && !toggle)) begin
                    state_nxt = SEQ_SAMP;
                end
            end
            SEQ_SAMP: begin
                if (toggle) begin
                    state_nxt = SEQ_WAIT;
                end else if (samp_end && !op_type) begin
                    state_nxt = SEQ_IDLE;
                end
            end
        endcase
    end

    // Timers are private to each instance; channels never share a count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SEQ_IDLE;
            pre_r <= 18'h00000;
            ms_r <= 9'h000;
        end else begin
            state_r <= state_nxt;
            pre_r <= (moved || tick) ? 18'h00000 : pre_r + 18'h00001;
            ms_r <= moved ? 9'h000 : (tick ? ms_r + 9'h001 : ms_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_d_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            mon_d_r <= mon_level;
            if (toggle) begin
                lvl_r <= mon_level;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= fin;
            if (fin) begin
                meas_r.last_cur <= sample;
                if (op_type) begin
                    meas_r.on_cur <= filt(meas_r.on_cur, sample);
                    meas_r.off_cur <= 16'h0000;
                end else if (lvl_r) begin
                    meas_r.on_cur <= filt(meas_r.on_cur, sample);
                end else begin
                    meas_r.off_cur <= filt(meas_r.off_cur, sample);
                end
            end else if (op_type) begin
                meas_r.off_cur <= 16'h0000;
            end
        end
    end

    assign meas = meas_r;
    assign done = done_r;
    assign busy = (state_r != SEQ_IDLE);

endmodule : hcm_chan

//--- sim/hcm_checker.sv
`timescale 1ns/1ps
module hcm_checker
    import hcm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hcm_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************************************
    // Bus phases
    // ****************************************
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_ready_wait;
        s_setup ##1 s_access |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready long");
    property p_ready_req;
        pready |-> s_access;
    endproperty
    a_ready_req: assert property (p_ready_req) else $error("ready unasked");
    property p_err_pair;
        pslverr |-> pready;
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("lone error");
    property p_unmapped;
        pready && paddr > OFS_STATUS |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error");
    property p_mapped;
        pready && paddr <= OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("false error");
    property p_unmapped_rd;
        pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("bad read");
    // Read data must not drift between reads
    property p_rd_hold;
        $changed(prdata) |-> pready && !pwrite;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("data moved");
    property p_mask_off;
        s_access ##0 pready && pwrite && paddr == OFS_INT_MASK && pwdata == 32'h0
            |=> ##1 !hcm_irq [*2];
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq kept");
endmodule : hcm_checker

bind hcm_top hcm_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hcm_irq(hcm_irq));

//--- sim/hcm_ct_model.sv
`timescale 1ns/1ps
module hcm_ct_model
    import hcm_pkg::*;
(
    input wire logic pclk,
    input wire logic [1:0] heat,
    input wire hcm_cur_t amps_1,
    input wire hcm_cur_t leak_1,
    input wire hcm_cur_t amps_2,
    input wire hcm_cur_t leak_2,
    output hcm_cur_t ct_sample_1,
    output hcm_cur_t ct_sample_2
);
    // Leak stands for a shorted heater, so off-state is not always zero
    always_ff @(posedge pclk) begin
        ct_sample_1 <= heat[0] ? amps_1 : leak_1;
        ct_sample_2 <= heat[1] ? amps_2 : leak_2;
    end
endmodule : hcm_ct_model

//--- sim/hcm_top_tb.sv
`timescale 1ns/1ps
module hcm_top_tb;
    import hcm_pkg::*;
    localparam int unsigned CMS = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, strap, hcm_irq, ps;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] outs;
    logic [1:0] alarm;
    hcm_cur_t s1, s2, amps_1, leak_1, amps_2, leak_2;
    int err_total, total_checks, n, sel1, tv, lv;
    logic [5:0] tt[4] = '{6'h00, 6'h04, 6'h2d, 6'h01};
    logic [2:0] tl[4] = '{3'h0, 3'h2, 3'h6, 3'h7};
    hcm_top #(.CYC_MS(CMS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl_out(outs[1:0]),
        .evt_out(outs[4:2]), .ct_sample_1(s1), .ct_sample_2(s2),
        .dual_ct_strap(strap), .ct_input_failure_alarm(alarm), .hcm_irq(hcm_irq));
    hcm_ct_model u_ct (.pclk(pclk), .heat({outs[0], outs[sel1]}), .amps_1(amps_1),
        .leak_1(leak_1), .amps_2(amps_2), .leak_2(leak_2), .ct_sample_1(s1),
        .ct_sample_2(s2));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            err_total++;
            results();
        end
        rd = prdata;
        ps = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Waits in clock cycles for the masked done interrupt
    task automatic wait_irq(input int lo, input int hi);
        n = 0;
        while (hcm_irq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n == 3000) begin
            err_total++;
            results();
        end
        chk(n >= lo && n <= hi, 1);
    endtask : wait_irq
    task automatic flip(input int b);
        outs <= outs ^ (5'h01 << b);
        @(posedge pclk);
    endtask : flip

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, outs} = '0;
        {amps_1, leak_1, amps_2, leak_2, sel1, err_total, total_checks} = '0;
        strap = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(0, OFS_CTRL, 0); chk(rd, 0);
        apb(0, OFS_WAIT, 0); chk(rd, 32'h001e001e);
        apb(0, OFS_STATUS, 0); chk(rd[0], 1);
        apb(0, 12'h030, 0); chk(ps, 1);
        chk(rd, 0);
        apb(1, OFS_WAIT, 32'h001e0005); apb(0, OFS_WAIT, 0); chk(rd, 32'h001e001e);
        apb(1, OFS_WAIT, 32'h001e0190); apb(0, OFS_WAIT, 0); chk(rd, 32'h001e012c);
        apb(1, OFS_WAIT, 32'h001e001e);
        for (int i = 0; i < 4; i++) begin
            apb(1, OFS_TURNLOOP, {16'h0108, 5'h00, tl[i], 2'h0, tt[i]});
            tv = (tt[i] == 0) ? 8 : ((tt[i] > 40) ? 40 : int'(tt[i]));
            lv = (tl[i] == 0) ? 1 : ((tl[i] > 6) ? 6 : int'(tl[i]));
            apb(0, OFS_RANGE1, 0); chk(rd, {16'(tv * 625 / lv), 16'(tv * 875 / lv)});
            apb(0, OFS_RANGE_LO, 0); chk(rd[15:0], 16'(tv * 5 / lv));
        end
        apb(0, OFS_RANGE2, 0); chk(rd, 32'h13881b58);
        $display("ranges done");
        apb(1, OFS_INT_MASK, 32'h1);
        leak_1 = 16'h0190;
        for (int s = 0; s < 5; s++) begin
            sel1 = s;
            amps_1 = 16'(1000 + 300 * s);
            apb(1, OFS_CTRL, 32'(s) << 4);
            flip(s);
            wait_irq(1295, 1310);
            apb(1, OFS_INT_STS, 32'hf);
            apb(0, OFS_MEAS1, 0); chk(rd, {16'h0, amps_1});
            chk(hcm_irq, 0);
        end
        $display("selectors done");
        sel1 = 0;
        apb(1, OFS_CTRL, 0);
        // Two early toggles must each restart the wait
        for (int k = 0; k < 3; k++) begin
            flip(0);
            if (k < 2) repeat (500) @(posedge pclk);
        end
        wait_irq(1295, 1310);
        apb(1, OFS_INT_STS, 32'hf);
        apb(0, OFS_MEAS1, 0); chk(rd, {16'h0190, amps_1});
        apb(1, OFS_TURNLOOP, 32'h01080604);
        for (int k = 0; k < 2; k++) begin
            amps_1 = k ? 16'hffff : 16'h02bc;
            leak_1 = amps_1;
            flip(0);
            wait_irq(1295, 1310);
            chk(alarm[0], !k);
            apb(0, OFS_INT_STS, 0); chk(rd[2], !k);
            apb(1, OFS_INT_STS, 32'hf);
        end
        $display("alarm done");
        amps_2 = 16'h012c;
        leak_2 = amps_2;
        apb(1, OFS_INT_MASK, 32'h2);
        apb(1, OFS_CTRL, 32'h2);
        wait_irq(0, 1110);
        apb(1, OFS_INT_STS, 32'hf);
        apb(0, OFS_MEAS2, 0); chk(rd, 32'h0000012c);
        amps_2 = 16'h0190;
        leak_2 = amps_2;
        wait_irq(0, 1110);
        apb(0, OFS_MEAS2, 0); chk(rd, 32'h00000138);
        apb(1, OFS_INT_MASK, 0);
        $display("measurement done");
        presetn <= 1'b0;
        strap <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1, OFS_CTRL, 32'h3);
        apb(0, OFS_CTRL, 0); chk(rd, 32'h1);
        apb(0, OFS_STATUS, 0); chk(rd[0], 0);
        $display("single done");
        results();
    end
endmodule : hcm_top_tb
